// >>> dma_susp_channel.sv
`include "dma_susp_map.svh"
module dma_susp_channel (
    input  wire logic        mclk,        // 100 MHz clock
    input  wire logic        reset_n,     // async reset, active low
    input  wire logic        clkEn,       // clock enable
    input  wire logic [7:0]  addr,        // register byte address
    input  wire logic [31:0] wdata,       // write data
    input  wire logic        wr,          // write strobe
    input  wire logic        rd,          // read strobe
    output logic [31:0]      rdata,       // read data, cycle after rd
    input  wire logic        evIn,        // event input, async
    input  wire logic        periphTrig,  // peripheral trigger
    input  wire logic        granted,     // arbiter grant to this channel
    input  wire logic        beatDone,    // bus access of a beat done
    input  wire logic        blockDone,   // block transfer done
    input  wire logic        wbDone,      // write-back stored
    input  wire logic        descFetch,   // descriptor fetched strobe
    input  wire logic        descValid,   // descriptor valid bit
    input  wire logic [1:0]  descBlkAct,  // descriptor block action
    input  wire logic [1:0]  descEvoSel,  // descriptor event output select
    output logic             arbReq,      // request to arbiter
    output logic             evAck,       // event acknowledge pulse
    output logic             evOut,       // event output pulse
    output logic             irq          // suspend interrupt request
);
    localparam logic [1:0] BLKACT_SUSP = 2'h2;

    dma_susp_pkg::chstate_e state;
    dma_susp_pkg::evact_e   evAct;
    logic        ctrlEn;
    logic        ctrlOn;
    logic        chEn;
    logic        evie;
    logic        evoe;
    logic [5:0]  trigSrc;
    logic [1:0]  cmd;
    logic        pend;
    logic        suspFlag;
    logic        suspIe;
    logic        fetchErr;
    logic        skipNext;
    logic        evHeld;
    logic        suspEvWait;
    logic        cblkOpen;
    logic        cblkAck;
    logic        trigArmed;
    logic [1:0]  evoSel;
    logic        evPulse;
    logic        ev;
    logic        suspReq;
    logic        doSusp;
    logic        blkSusp;
    logic        trigIn;
    logic        activeStop;
    logic        enterSusp;
    logic        resumeNow;
    logic        irqNext;

    // ---------------------------------------------------------------
    // event input and output
    // ---------------------------------------------------------------
    // resynchronised events only
    event_sync u_sync (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .clkEn    (clkEn),
        .async_in (evIn),
        .pulse    (evPulse)
    );

    event_out_gen u_evo (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .clkEn     (clkEn),
        .enable    (evoe),
        .sel       (evoSel),
        .beatDone  (beatDone & granted),
        .blockDone (blockDone & granted),
        .evOut     (evOut)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign ev = evPulse & evie & chEn;

    // block suspend unless skipped by command or held skip event
    assign blkSusp = blockDone & granted & (descBlkAct == BLKACT_SUSP);

    // suspend waits for current access to end
    assign suspReq = (cmd == `CMD_SUSPEND) | suspEvWait;
    assign doSusp = (suspReq & (~granted | beatDone) & ~skipNext)
                  | (blkSusp & ~skipNext & ~evHeld)
                  | (descFetch & ~descValid);
    assign enterSusp = doSusp & (state == dma_susp_pkg::CH_RUN);
    assign resumeNow = (state == dma_susp_pkg::CH_SUSP) &
                       ((cmd == `CMD_RESUME) |
                        (ev & (evAct == dma_susp_pkg::EVACT_RESUME ||
                               evAct == dma_susp_pkg::EVACT_SSKIP)));
    // active channel waits for write-back
    assign activeStop = ~granted | wbDone;

    always_comb begin
        trigIn = 1'b0;
        if (!ev || pend) begin
            trigIn = 1'b0;
        end else if (evAct == dma_susp_pkg::EVACT_TRIG && trigSrc == 6'h00) begin
            trigIn = 1'b1;
        end else if (evAct == dma_susp_pkg::EVACT_TRIG
                     || evAct == dma_susp_pkg::EVACT_CTRIG) begin
            trigIn = periphTrig | trigArmed;
        end
    end

    // ---------------------------------------------------------------
    // channel state machine
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= dma_susp_pkg::CH_OFF;
        end else if (clkEn) begin
            case (state)
                dma_susp_pkg::CH_OFF: begin
                    if (chEn && ctrlEn) begin
                        state <= dma_susp_pkg::CH_RUN;
                    end
                end
                dma_susp_pkg::CH_RUN: begin
                    if (!chEn || !ctrlEn) begin
                        state <= dma_susp_pkg::CH_STOP;
                    end else if (enterSusp) begin
                        state <= dma_susp_pkg::CH_SUSP;
                    end
                end
                dma_susp_pkg::CH_SUSP: begin
                    if (!chEn || !ctrlEn) begin
                        state <= dma_susp_pkg::CH_STOP;
                    end else if (resumeNow) begin
                        state <= dma_susp_pkg::CH_RUN;
                    end
                end
                dma_susp_pkg::CH_STOP: begin
                    if (activeStop) begin
                        state <= dma_susp_pkg::CH_OFF;
                    end
                end
                default: begin
                    state <= dma_susp_pkg::CH_OFF;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // configuration and command registers
    // ---------------------------------------------------------------
    // software abort via enable bits
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlEn  <= 1'b0;
            chEn    <= 1'b0;
            evAct   <= dma_susp_pkg::EVACT_NOACT;
            evie    <= 1'b0;
            evoe    <= 1'b0;
            trigSrc <= 6'h00;
            suspIe  <= 1'b0;
        end else if (clkEn) begin
            if (wr && hit(addr, `OFS_CTRL)) begin
                ctrlEn <= wdata[0];
            end
            if (wr && hit(addr, `OFS_CHCTRLA)) begin
                chEn <= wdata[0];
            end else if (!ctrlEn) begin
                chEn <= 1'b0;
            end
            if (wr && hit(addr, `OFS_CHCTRLB)) begin
                evAct   <= dma_susp_pkg::evact_e'(wdata[`CB_EVACT_LSB +: 3]);
                evie    <= wdata[`CB_EVIE_BIT];
                evoe    <= wdata[`CB_EVOE_BIT];
                trigSrc <= wdata[`CB_TRIG_LSB +: 6];
            end
            if (wr && hit(addr, `OFS_CHINT)) begin
                suspIe <= wdata[`IE_SUSP_BIT];
            end
        end
    end

    // command clears itself once acted on
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cmd <= `CMD_NOACT;
        end else if (clkEn) begin
            if (wr && hit(addr, `OFS_CHCTRLB)) begin
                cmd <= wdata[`CB_CMD_LSB +: 2];
            end else if (state == dma_susp_pkg::CH_OFF || state == dma_susp_pkg::CH_STOP) begin
                cmd <= `CMD_NOACT;
            end else if (cmd == `CMD_SUSPEND && (enterSusp || skipNext)) begin
                cmd <= `CMD_NOACT;
            end else if (cmd == `CMD_RESUME) begin
                cmd <= `CMD_NOACT;
            end
        end
    end

    // resume before suspend skips next suspend
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            skipNext <= 1'b0;
        end else if (clkEn) begin
            if (state != dma_susp_pkg::CH_RUN) begin
                skipNext <= (state == dma_susp_pkg::CH_SUSP) ? 1'b0 : 1'b0;
            end else if (cmd == `CMD_RESUME) begin
                skipNext <= 1'b1;
            end else if ((suspReq && (~granted | beatDone)) || blkSusp) begin
                skipNext <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // event action state
    // ---------------------------------------------------------------
    // held events
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            suspEvWait <= 1'b0;
            evHeld     <= 1'b0;
            cblkOpen   <= 1'b0;
            cblkAck    <= 1'b0;
            trigArmed  <= 1'b0;
        end else if (clkEn) begin
            if (state != dma_susp_pkg::CH_RUN) begin
                suspEvWait <= 1'b0;
            end else if (ev && evAct == dma_susp_pkg::EVACT_SUSPEND) begin
                suspEvWait <= 1'b1;
            end
            if (state == dma_susp_pkg::CH_OFF) begin
                evHeld <= 1'b0;
            end else if (ev && evAct == dma_susp_pkg::EVACT_SSKIP
                         && state == dma_susp_pkg::CH_RUN) begin
                evHeld <= 1'b1;
            end else if (blkSusp) begin
                evHeld <= 1'b0;
            end
            if (state == dma_susp_pkg::CH_OFF || (blockDone && granted)) begin
                cblkOpen <= 1'b0;
            end else if (ev && evAct == dma_susp_pkg::EVACT_CBLOCK) begin
                cblkOpen <= 1'b1;
            end
            cblkAck <= cblkOpen & blockDone & granted;
            // peripheral trigger waits for an event when trigSrc is nonzero
            if (pend || state == dma_susp_pkg::CH_OFF) begin
                trigArmed <= 1'b0;
            end else if (periphTrig && evAct == dma_susp_pkg::EVACT_TRIG && trigSrc != 6'h00) begin
                trigArmed <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            evAck <= 1'b0;
        end else if (clkEn) begin
            evAck <= trigIn
                   | (ev && (evAct == dma_susp_pkg::EVACT_RESUME))
                   | (ev && evAct == dma_susp_pkg::EVACT_SSKIP && state == dma_susp_pkg::CH_SUSP)
                   | (evHeld & blkSusp)
                   | (suspEvWait & (~granted | beatDone))
                   | cblkAck;
        end
    end

    // ---------------------------------------------------------------
    // pending, flags, interrupt
    // ---------------------------------------------------------------
    // pending still set while suspended
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pend <= 1'b0;
        end else if (clkEn) begin
            if (trigIn && state != dma_susp_pkg::CH_OFF) begin
                pend <= 1'b1;
            end else if (state == dma_susp_pkg::CH_OFF || (granted && blockDone)) begin
                pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            suspFlag <= 1'b0;
            fetchErr <= 1'b0;
        end else if (clkEn) begin
            if (enterSusp) begin
                suspFlag <= 1'b1;
            end else if ((wr && hit(addr, `OFS_CHINT) && wdata[`IF_SUSP_BIT])
                         || (resumeNow && ev)) begin
                suspFlag <= 1'b0;
            end
            if (enterSusp && descFetch && !descValid) begin
                fetchErr <= 1'b1;
            end else if (wr && hit(addr, `OFS_STATUS) && wdata[0]) begin
                fetchErr <= 1'b0;
            end
        end
    end

    assign irqNext = suspFlag & suspIe;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq    <= 1'b0;
            arbReq <= 1'b0;
            ctrlOn <= 1'b0;
            evoSel <= 2'h0;
        end else if (clkEn) begin
            irq    <= irqNext;
            arbReq <= (state == dma_susp_pkg::CH_RUN) & pend & ctrlEn
                    & ~(evAct == dma_susp_pkg::EVACT_CBLOCK & ~cblkOpen);
            ctrlOn <= ctrlEn | (state != dma_susp_pkg::CH_OFF);
            if (descFetch) begin
                evoSel <= descEvoSel;
            end
        end
    end

    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    // enables read back running state
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 32'h00000000;
        end else if (clkEn) begin
            if (!rd) begin
                rdata <= 32'h00000000;
            end else if (hit(addr, `OFS_CTRL)) begin
                rdata <= {31'h0, ctrlOn};
            end else if (hit(addr, `OFS_CHCTRLA)) begin
                rdata <= {31'h0, state != dma_susp_pkg::CH_OFF};
            end else if (hit(addr, `OFS_CHCTRLB)) begin
                rdata <= {14'h0, cmd, 2'h0, trigSrc, 3'h0, evoe, evie, evAct};
            end else if (hit(addr, `OFS_CHSTATUS)) begin
                rdata <= {29'h0, state == dma_susp_pkg::CH_SUSP, granted, pend};
            end else if (hit(addr, `OFS_CHINT)) begin
                rdata <= {21'h0, suspIe, 7'h0, suspFlag, 2'h0};
            end else if (hit(addr, `OFS_STATUS)) begin
                rdata <= {31'h0, fetchErr};
            end else begin
                rdata <= 32'h00000000;
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_fetchBad;
        clkEn && descFetch && !descValid && state == dma_susp_pkg::CH_RUN && chEn && ctrlEn;
    endsequence

    property p_fetchErr;
        @(posedge mclk) disable iff (!reset_n)
        s_fetchBad |=> state == dma_susp_pkg::CH_SUSP && fetchErr;
    endproperty
    a_fetchErr: assert property (p_fetchErr) else $error("no suspend on bad descriptor");

    property p_suspFlag;
        @(posedge mclk) disable iff (!reset_n)
        (clkEn && enterSusp && chEn && ctrlEn) |=> suspFlag;
    endproperty
    a_suspFlag: assert property (p_suspFlag) else $error("suspend flag missing");

    property p_noArbSusp;
        @(posedge mclk) disable iff (!reset_n)
        $past(state) == dma_susp_pkg::CH_SUSP |-> !arbReq;
    endproperty
    a_noArbSusp: assert property (p_noArbSusp) else $error("suspended channel requests bus");

    property p_disClears;
        @(posedge mclk) disable iff (!reset_n)
        (clkEn && state == dma_susp_pkg::CH_SUSP && !chEn) |=> state == dma_susp_pkg::CH_STOP;
    endproperty
    a_disClears: assert property (p_disClears) else $error("suspend kept after disable");

    property p_normAck;
        @(posedge mclk) disable iff (!reset_n)
        (clkEn && ev && !pend && evAct == dma_susp_pkg::EVACT_TRIG && trigSrc == 6'h00
         && state != dma_susp_pkg::CH_OFF) |=> evAck && pend;
    endproperty
    a_normAck: assert property (p_normAck) else $error("normal event not taken");

    property p_resumeEv;
        @(posedge mclk) disable iff (!reset_n)
        (clkEn && ev && evAct == dma_susp_pkg::EVACT_RESUME && state == dma_susp_pkg::CH_SUSP
         && chEn && ctrlEn) |=> state == dma_susp_pkg::CH_RUN && evAck && !suspFlag;
    endproperty
    a_resumeEv: assert property (p_resumeEv) else $error("resume event failed");

    property p_cmdClr;
        @(posedge mclk) disable iff (!reset_n)
        (clkEn && cmd == `CMD_SUSPEND && enterSusp && !wr) |=> cmd == `CMD_NOACT;
    endproperty
    a_cmdClr: assert property (p_cmdClr) else $error("suspend command not cleared");

    property p_enRead;
        @(posedge mclk) disable iff (!reset_n)
        (clkEn && rd && hit(addr, `OFS_CHCTRLA) && state != dma_susp_pkg::CH_OFF) |=> rdata[0];
    endproperty
    a_enRead: assert property (p_enRead) else $error("enable reads zero while running");
endmodule

// >>> dma_susp_map.svh
`ifndef DMA_SUSP_MAP_SVH
`define DMA_SUSP_MAP_SVH

// register offsets (word index == byte address / 4)
`define OFS_CTRL        8'h00
`define OFS_CHSEL       8'h04
`define OFS_CHCTRLA     8'h08
`define OFS_CHCTRLB     8'h0c
`define OFS_CHSTATUS    8'h10
`define OFS_CHINT       8'h14
`define OFS_STATUS      8'h18

// command field codes
`define CMD_NOACT       2'h0
`define CMD_SUSPEND     2'h1
`define CMD_RESUME      2'h2

// control B field positions
`define CB_EVACT_LSB    0
`define CB_EVIE_BIT     3
`define CB_EVOE_BIT     4
`define CB_TRIG_LSB     8
`define CB_CMD_LSB      16

// status / flag bit positions
`define ST_PEND_BIT     0
`define ST_BUSY_BIT     1
`define ST_SUSP_BIT     2
`define IF_SUSP_BIT     2
`define IE_SUSP_BIT     10

// event output pulse width, in clock cycles
`define EVOUT_WIDTH_CYC 1

`endif

// >>> dma_susp_pkg.sv
package dma_susp_pkg;

    // event input actions
    typedef enum logic [2:0] {
        EVACT_NOACT   = 3'h0,
        EVACT_TRIG    = 3'h1,
        EVACT_CTRIG   = 3'h2,
        EVACT_CBLOCK  = 3'h3,
        EVACT_SUSPEND = 3'h4,
        EVACT_RESUME  = 3'h5,
        EVACT_SSKIP   = 3'h6
    } evact_e;

    // channel run state, one-hot
    typedef enum logic [3:0] {
        CH_OFF  = 4'b0001,
        CH_RUN  = 4'b0010,
        CH_SUSP = 4'b0100,
        CH_STOP = 4'b1000
    } chstate_e;

endpackage

// >>> event_sync.sv
// two-flop synchroniser plus rising-edge pulse for an outside event line
module event_sync (
    input  wire logic mclk,      // clock
    input  wire logic reset_n,   // async reset, active low
    input  wire logic clkEn,     // clock enable
    input  wire logic async_in,  // raw event line
    output logic      pulse      // one-cycle pulse on rising edge
);
    logic meta;
    logic stable;
    logic last;

    // ---------------------------------------------------------------
    // synchroniser
    // ---------------------------------------------------------------
    // meta is read only by stable
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta   <= 1'b0;
            stable <= 1'b0;
            last   <= 1'b0;
        end else if (clkEn) begin
            meta   <= async_in;
            stable <= meta;
            last   <= stable;
        end
    end

    assign pulse = stable & ~last & clkEn;
endmodule

// >>> event_out_gen.sv
// one-cycle event output after beat or block
module event_out_gen (
    input  wire logic mclk,       // clock
    input  wire logic reset_n,    // async reset, active low
    input  wire logic clkEn,      // clock enable
    input  wire logic enable,     // event output enable
    input  wire logic [1:0] sel,  // 0 none, 1 block, 2 beat
    input  wire logic beatDone,   // beat finished
    input  wire logic blockDone,  // block finished
    output logic      evOut       // registered pulse
);
    // ---------------------------------------------------------------
    // pulse register
    // ---------------------------------------------------------------
    // width is one cycle since the strobes are themselves single-cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            evOut <= 1'b0;
        end else if (clkEn) begin
            evOut <= enable & ((sel == 2'h1 & blockDone) | (sel == 2'h2 & beatDone));
        end
    end

    a_evpulse: assert property (@(posedge mclk) disable iff (!reset_n)
        evOut |=> !evOut || $past(clkEn) == 1'b0 || $past(beatDone)) else $error("evout too long");
endmodule

// >>> bus_slave_model.sv
// far-side bus model: grants a requesting channel, two-beat blocks
module bus_slave_model (
    input  wire logic mclk,      // clock
    input  wire logic reset_n,   // async reset, active low
    input  wire logic arbReq,    // channel request
    output logic      granted,   // channel is active
    output logic      beatDone,  // beat access done
    output logic      blockDone, // block done
    output logic      wbDone     // write-back stored
);
    logic [1:0] beats;
    // one beat every other cycle, so a suspend can land between beats
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            {granted, beatDone, blockDone, wbDone, beats} <= 6'h0;
        end else begin
            granted   <= arbReq;
            beatDone  <= granted && !beatDone;
            blockDone <= granted && !beatDone && beats[0];
            wbDone    <= granted && !arbReq;
            beats     <= beats + {1'h0, beatDone};
        end
    end
endmodule

// >>> tb_dma_susp_channel.sv
module tb_dma_susp_channel;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk, reset_n, wr, rd, evIn, descFetch, descValid;
    logic        granted, beatDone, blockDone, wbDone, arbReq, evAck, evOut, irq;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic [1:0]  blkAct, evoSel;
    int          bad_count, n_tests;

    dma_susp_channel i_dma_susp_channel (.mclk, .reset_n, .clkEn(1'h1), .addr, .wdata, .wr,
        .rd, .rdata, .evIn, .periphTrig(1'h0), .granted, .beatDone, .blockDone, .wbDone,
        .descFetch, .descValid, .descBlkAct(blkAct), .descEvoSel(evoSel), .arbReq, .evAck,
        .evOut, .irq);
    bus_slave_model i_bus_slave_model (.mclk, .reset_n, .arbReq, .granted, .beatDone,
        .blockDone, .wbDone);

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        {addr, wdata, wr} <= {a, v, 1'h1};
        @(posedge mclk);
        wr <= 1'h0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_bit(input logic [7:0] a, input int b, input logic e);
        @(posedge mclk);
        {addr, rd} <= {a, 1'h1};
        @(posedge mclk);
        rd <= 1'h0;
        #1;
        chk({31'h0, rdata[b]}, {31'h0, e});
    endtask
    // rising edge on the event line, held until acknowledged
    task automatic fire_event();
        @(posedge mclk);
        evIn <= 1'h1;
        for (int i = 0; i < 20; i++) begin
            @(posedge mclk);
            #1;
            if (evAck === 1'h1) break;
            if (i == 19) bad_count++;
        end
        if (evAck !== 1'h1) give_verdict();
        @(posedge mclk);
        evIn <= 1'h0;
    endtask

    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        {reset_n, wr, rd, evIn, descFetch, descValid, addr, wdata} = 46'h0;
        {blkAct, evoSel} = 4'h0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'h1;
        rd_bit(8'h08, 0, 1'h0);
        wr_reg(8'h00, 32'h1);
        wr_reg(8'h08, 32'h1);
        wr_reg(8'h14, 32'h400);
        wr_reg(8'h0c, 32'h9);
        fire_event();
        $display("normal event test done");
        wr_reg(8'h0c, 32'h10009);
        rd_bit(8'h10, 2, 1'h1);
        rd_bit(8'h0c, 16, 1'h0);
        rd_bit(8'h14, 2, 1'h1);
        chk({31'h0, irq}, 32'h1);
        rd_bit(8'h08, 0, 1'h1);
        chk({31'h0, arbReq}, 32'h0);
        wr_reg(8'h0c, 32'hd);
        fire_event();
        rd_bit(8'h10, 2, 1'h0);
        rd_bit(8'h14, 2, 1'h0);
        $display("suspend and resume test done");
        // resume ahead of suspend: the suspend is skipped
        wr_reg(8'h0c, 32'h20009);
        wr_reg(8'h0c, 32'h10009);
        rd_bit(8'h10, 2, 1'h0);
        // valid descriptor: block event out, suspend at block end
        wr_reg(8'h0c, 32'h19);
        @(posedge mclk);
        {descFetch, descValid, blkAct, evoSel} <= 6'h39;
        @(posedge mclk);
        descFetch <= 1'h0;
        fire_event();
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            #1;
            if (evOut === 1'h1) break;
        end
        chk({31'h0, evOut}, 32'h1);
        rd_bit(8'h10, 2, 1'h1);
        wr_reg(8'h0c, 32'h20009);
        rd_bit(8'h10, 2, 1'h0);
        @(posedge mclk);
        blkAct <= 2'h0;
        $display("block suspend and event output test done");
        @(posedge mclk);
        {descFetch, descValid} <= 2'h2;
        @(posedge mclk);
        descFetch <= 1'h0;
        rd_bit(8'h18, 0, 1'h1);
        rd_bit(8'h10, 2, 1'h1);
        wr_reg(8'h08, 32'h0);
        // the enable reads one until the stop state has drained
        repeat (3) @(posedge mclk);
        rd_bit(8'h08, 0, 1'h0);
        rd_bit(8'h10, 2, 1'h0);
        wr_reg(8'h08, 32'h1);
        wr_reg(8'h00, 32'h0);
        repeat (3) @(posedge mclk);
        rd_bit(8'h08, 0, 1'h0);
        rd_bit(8'h00, 0, 1'h0);
        $display("fetch error and abort test done");
        give_verdict();
    end
endmodule
